// [bench/sfs_master_model.sv]
// Serial bus master model that drives the slave's pins in clock mode 0 or 3.
`default_nettype none
module sfs_master_model (
    input wire logic i_clk,
    input wire logic i_so,
    input wire logic i_so_oe,
    output logic o_cs_n,
    output logic o_sck,
    output logic o_si,
    output logic o_hold_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic mode3 = 1'b0;
    logic so_last = 1'b0;
    // The output line has no pull; a released line shows the inverse of its last level so stale data never matches.
    wire logic so_line = i_so_oe ? i_so : ~so_last;

    // Remembers the last driven level of the output line.
    always @(posedge i_clk) begin
        if (i_so_oe) begin
            so_last <= i_so;
        end
    end

    // Pins start deselected with the clock low.
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
        o_hold_n = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    // The clock settles at its idle level while still deselected, so a switch to mode 3 makes no
    // false rising edge; select then leads the first rising edge by 24 reference cycles in either mode.
    task automatic start();
        tick(1);
        o_sck <= mode3;
        tick(12);
        o_cs_n <= 1'b0;
        tick(12);
    endtask

    // The clock returns to its idle level before select rises.
    task automatic stop();
        o_sck <= mode3;
        tick(12);
        o_cs_n <= 1'b1;
        tick(12);
    endtask

    // Shifts bits hi down to lo, most significant first; 12 plus 13 reference cycles make one 125 ns period.
    task automatic shift(input logic [7:0] tx, input int hi, input int lo, inout logic [7:0] rx);
        for (int i = hi; i >= lo; i--) begin
            o_sck <= 1'b0;
            o_si <= tx[i];
            tick(12);
            o_sck <= 1'b1;
            rx[i] = so_line;
            tick(13);
        end
    endtask

    // Pause with select held low, wiggle clock and data, then resume at the clock level of the pause.
    task automatic pause(output logic oe_seen);
        o_hold_n <= 1'b0;
        tick(12);
        o_sck <= ~o_sck;
        o_si <= ~o_si;
        tick(12);
        oe_seen = i_so_oe;
        o_sck <= ~o_sck;
        tick(12);
        o_hold_n <= 1'b1;
        tick(12);
    endtask
endmodule
`default_nettype wire

// [bench/sfs_status_slave_test.sv]
// Self-checking bench for the serial status slave with an array model and a master model.
`default_nettype none
module sfs_status_slave_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] IDENT = 32'h3c5a_a5c3; // Arbitrary identifier value.
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wp_n = 1'b1;
    logic [7:0] mem_rdata = 8'h00;
    logic so;
    logic so_oe;
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    sfs_pkg::sfs_mem_t mem_req;
    logic [7:0] status;
    logic [7:0] mem [0:8191];
    logic [7:0] shadow [0:8191];
    logic [7:0] rxq [$];
    logic [7:0] rx;
    logic oe_seen;
    logic [15:0] starts [3] = '{16'hf7ff, 16'h0fff, 16'h1fff};
    int limit [4] = '{8192, 6144, 4096, 0};
    int failures = 0;
    int samples_checked = 0;
    logic [12:0] a;

    always #2.5 clk = ~clk;

    sfs_status_slave #(.IDENT(IDENT)) DUT (
        .I_REF_CLK(clk), .I_RST_N(rst_n), .I_CS_N(cs_n), .I_SCK(sck), .I_SI(si), .I_HOLD_N(hold_n),
        .I_WP_N(wp_n), .I_MEM_RDATA(mem_rdata), .O_SO(so), .O_SO_OE(so_oe), .O_MEM(mem_req), .O_STATUS(status)
    );

    sfs_master_model master (
        .i_clk(clk), .i_so(so), .i_so_oe(so_oe), .o_cs_n(cs_n), .o_sck(sck), .o_si(si), .o_hold_n(hold_n)
    );

    // Array model: writes land at once, read data is valid the cycle after the request.
    always @(posedge clk) begin
        if (mem_req.we) mem[mem_req.addr] <= mem_req.wdata;
        if (mem_req.re) mem_rdata <= mem[mem_req.addr];
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (failures == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One selected frame; every byte received is kept in order.
    task automatic frame(input logic [7:0] tx [$]);
        rxq = {};
        master.start();
        foreach (tx[i]) begin
            master.shift(tx[i], 7, 0, rx);
            rxq.push_back(rx);
        end
        master.stop();
    endtask

    // A hang anywhere ends the run as a mismatch.
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        foreach (mem[i]) begin
            mem[i] = 8'h00;
            shadow[i] = 8'h00;
        end
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        check("status after reset", 8'h00, status);
        // Clocking a full enable code while deselected must change nothing.
        master.shift(sfs_pkg::CMD_ENABLE_WRITE, 7, 0, rx);
        master.stop();
        check("oe while deselected", 1'b0, so_oe);
        check("latch after deselected code", 8'h00, status);
        master.start();
        master.shift(sfs_pkg::CMD_ENABLE_WRITE, 7, 1, rx);
        master.stop();
        check("latch after short code", 8'h00, status);
        // Enable, repeated status read and disable in both clock modes.
        for (int m = 0; m < 2; m++) begin
            master.mode3 = m[0];
            frame({sfs_pkg::CMD_ENABLE_WRITE});
            frame({sfs_pkg::CMD_STATUS_READ, 8'h00, 8'h00});
            check("status read", 8'h02, rxq[1]);
            check("status reread", 8'h02, rxq[2]);
            frame({sfs_pkg::CMD_DISABLE_WRITE});
            check("latch after disable", 8'h00, status);
        end
        master.mode3 = 1'b0;
        // Status write stores bits 7 to 2 only and clears the latch at deselect.
        frame({sfs_pkg::CMD_ENABLE_WRITE});
        frame({sfs_pkg::CMD_STATUS_WRITE, 8'hff});
        check("status after write", 8'hfc, status);
        frame({sfs_pkg::CMD_STATUS_READ, 8'h00});
        check("status readback", 8'hfc, rxq[1]);
        wp_n <= 1'b0;
        frame({sfs_pkg::CMD_ENABLE_WRITE});
        frame({sfs_pkg::CMD_STATUS_WRITE, 8'h00});
        check("status write with pin low", 8'hfc, status);
        wp_n <= 1'b1;
        frame({sfs_pkg::CMD_STATUS_WRITE, 8'h00});
        check("status write without latch", 8'hfc, status);
        // Every protect field against each region boundary, including the wrap at the top.
        for (int bp = 0; bp < 4; bp++) begin
            frame({sfs_pkg::CMD_ENABLE_WRITE});
            frame({sfs_pkg::CMD_STATUS_WRITE, 8'(bp << 2)});
            check("protect field", 8'(bp << 2), status);
            foreach (starts[k]) begin
                frame({sfs_pkg::CMD_ENABLE_WRITE});
                frame({sfs_pkg::CMD_MEM_WRITE, starts[k][15:8], starts[k][7:0],
                       8'(129 + 16 * bp + 2 * k), 8'(130 + 16 * bp + 2 * k)});
                check("latch after array write", 1'b0, status[1]);
                for (int j = 0; j < 2; j++) begin
                    a = 13'(starts[k] + 16'(j));
                    if (int'(a) < limit[bp]) shadow[a] = 8'(129 + 16 * bp + 2 * k + j);
                end
            end
        end
        // Array write while the latch is clear is dropped.
        frame({sfs_pkg::CMD_ENABLE_WRITE});
        frame({sfs_pkg::CMD_STATUS_WRITE, 8'h00});
        frame({sfs_pkg::CMD_MEM_WRITE, 8'h01, 8'h00, 8'h5a});
        frame({sfs_pkg::CMD_MEM_READ, 8'he1, 8'h00, 8'h00});
        check("array write without latch", 8'h00, rxq[3]);
        foreach (starts[k]) begin
            a = 13'(starts[k]);
            frame({sfs_pkg::CMD_MEM_READ, starts[k][15:8], starts[k][7:0], 8'h00, 8'h00});
            check("array byte", shadow[a], rxq[3]);
            check("array next byte", shadow[13'(a + 13'h1)], rxq[4]);
        end
        frame({sfs_pkg::CMD_IDENT_READ, 8'h00, 8'h00, 8'h00, 8'h00});
        check("identifier", IDENT, {rxq[1], rxq[2], rxq[3], rxq[4]});
        // Pause in the middle of a status byte: output released, clock ignored, byte intact.
        frame({sfs_pkg::CMD_ENABLE_WRITE});
        master.start();
        master.shift(sfs_pkg::CMD_STATUS_READ, 7, 0, rx);
        master.shift(8'h00, 7, 4, rx);
        master.pause(oe_seen);
        master.shift(8'h00, 3, 0, rx);
        master.stop();
        check("oe during pause", 1'b0, oe_seen);
        check("status across pause", 8'h02, rx);
        stop_test();
    end
endmodule
`default_nettype wire

// [verilog/sfs_pkg.sv]
// Shared constants and types of the serial memory slave front end.
`default_nettype none
package sfs_pkg;
    // Serial framing.
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam int ADDR_W = 13;
    localparam logic [1:0] ID_LAST = 2'h3;

    // Command codes.
    localparam logic [7:0] CMD_ENABLE_WRITE = 8'h06;
    localparam logic [7:0] CMD_DISABLE_WRITE = 8'h04;
    localparam logic [7:0] CMD_STATUS_READ = 8'h05;
    localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
    localparam logic [7:0] CMD_MEM_READ = 8'h03;
    localparam logic [7:0] CMD_MEM_WRITE = 8'h02;
    localparam logic [7:0] CMD_IDENT_READ = 8'h9f;

    // Status register layout; the stored field covers bits 7 down to 2.
    localparam int SR_PROT_EN_BIT = 7;
    localparam int SR_NV_LO_BIT = 2;
    localparam int SR_LATCH_BIT = 1;
    localparam logic [5:0] SR_NV_RESET = 6'h00;
    localparam logic SR_LATCH_RESET = 1'b0;

    // Block-protect field encodings.
    localparam logic [1:0] BP_NONE = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF = 2'h2;
    localparam logic [1:0] BP_ALL = 2'h3;

    // Pins of the serial port as one bundle.
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic hold_n;
        logic wp_n;
    } sfs_pins_t;

    localparam sfs_pins_t PINS_RESET = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};

    // Request to the memory array.
    typedef struct packed {
        logic we;
        logic re;
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
    } sfs_mem_t;

    typedef enum logic [2:0] {
        PH_CMD = 3'b000,
        PH_ADDR_HI = 3'b001,
        PH_ADDR_LO = 3'b010,
        PH_DATA = 3'b011,
        PH_IGNORE = 3'b100
    } sfs_phase_t;
endpackage
`default_nettype wire

// [verilog/sfs_status_slave.sv]
// Serial slave front end with status register of the ferroelectric memory.
`default_nettype none
module sfs_status_slave #(
    parameter logic [31:0] IDENT = 32'h5ac3_3ca5 // Arbitrary identifier value.
) (
    input wire logic I_REF_CLK,
    input wire logic I_RST_N,
    input wire logic I_CS_N,
    input wire logic I_SCK,
    input wire logic I_SI,
    input wire logic I_HOLD_N,
    input wire logic I_WP_N,
    input wire logic [7:0] I_MEM_RDATA,
    output logic O_SO,
    output logic O_SO_OE,
    output sfs_pkg::sfs_mem_t O_MEM,
    output logic [7:0] O_STATUS
);
    sfs_pkg::sfs_pins_t raw, pins;
    sfs_pkg::sfs_phase_t phase, next_phase;
    logic sck_d, cs_d, mem_we, mem_re, re_d, step, write_enable_latch, wr_seen, drv, freeze;
    logic [2:0] bit_cnt;
    logic [7:0] shift, opcode, wdata, out_sh;
    logic [sfs_pkg::ADDR_W-1:0] addr;
    logic [5:0] stat_nv;
    logic [1:0] id_cnt;

    ////////////////////////////////////////////////////////////////////////////
    // Pin capture and edge finding.

    assign raw = '{cs_n: I_CS_N, sck: I_SCK, si: I_SI, hold_n: I_HOLD_N, wp_n: I_WP_N};

    sfs_sync #(
        .W(5),
        .RST_VAL(sfs_pkg::PINS_RESET)
    ) u_sync (
        .i_clk(I_REF_CLK),
        .i_rst_n(I_RST_N),
        .i_d(raw),
        .o_q(pins)
    );

    // Edges count only while selected and not paused; idle level is free.
    wire active = !pins.cs_n && pins.hold_n;
    wire sck_rise = active && pins.sck && !sck_d;
    wire sck_fall = active && !pins.sck && sck_d;
    wire cs_rise = pins.cs_n && !cs_d;

    ////////////////////////////////////////////////////////////////////////////
    // Command decode.

    wire [7:0] next_byte = {shift[6:0], pins.si};
    wire byte_done = sck_rise && (bit_cnt == sfs_pkg::BIT_LAST);
    wire cmd_done = byte_done && (phase == sfs_pkg::PH_CMD);
    wire data_done = byte_done && (phase == sfs_pkg::PH_DATA);
    wire hi_done = byte_done && (phase == sfs_pkg::PH_ADDR_HI);
    wire lo_done = byte_done && (phase == sfs_pkg::PH_ADDR_LO);
    wire [7:0] cur_op = (phase == sfs_pkg::PH_CMD) ? next_byte : opcode;
    wire op_sread = cur_op == sfs_pkg::CMD_STATUS_READ;
    wire op_swrite = cur_op == sfs_pkg::CMD_STATUS_WRITE;
    wire op_mread = cur_op == sfs_pkg::CMD_MEM_READ;
    wire op_mwrite = cur_op == sfs_pkg::CMD_MEM_WRITE;
    wire op_ident = cur_op == sfs_pkg::CMD_IDENT_READ;
    wire is_enable = cmd_done && (next_byte == sfs_pkg::CMD_ENABLE_WRITE);
    wire is_disable = cmd_done && (next_byte == sfs_pkg::CMD_DISABLE_WRITE);

    // Phase sequencing per byte boundary.
    always_comb begin
        next_phase = phase;
        unique case (phase)
            sfs_pkg::PH_CMD: begin
                if (op_mread || op_mwrite) begin
                    next_phase = sfs_pkg::PH_ADDR_HI;
                end else if (op_sread || op_swrite || op_ident) begin
                    next_phase = sfs_pkg::PH_DATA;
                end else begin
                    next_phase = sfs_pkg::PH_IGNORE;
                end
            end
            sfs_pkg::PH_ADDR_HI: next_phase = sfs_pkg::PH_ADDR_LO;
            sfs_pkg::PH_ADDR_LO: next_phase = sfs_pkg::PH_DATA;
            sfs_pkg::PH_DATA: next_phase = op_swrite ? sfs_pkg::PH_IGNORE : sfs_pkg::PH_DATA;
            default: next_phase = sfs_pkg::PH_IGNORE;
        endcase
    end

    // Receive shifter; deselect drops any partial code so it never runs.
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            bit_cnt <= 3'h0;
            shift <= 8'h00;
            phase <= sfs_pkg::PH_CMD;
            opcode <= 8'h00;
        end else if (pins.cs_n) begin
            bit_cnt <= 3'h0;
            phase <= sfs_pkg::PH_CMD;
        end else if (sck_rise) begin
            shift <= next_byte;
            bit_cnt <= bit_cnt + 3'h1;
            if (byte_done) begin
                phase <= next_phase;
            end
            if (cmd_done) begin
                opcode <= next_byte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Array access and protection.

    wire [1:0] bp = stat_nv[1:0];
    wire top_half = addr[sfs_pkg::ADDR_W-1];
    wire top_quarter = top_half && addr[sfs_pkg::ADDR_W-2];
    wire prot = (bp == sfs_pkg::BP_ALL) || ((bp == sfs_pkg::BP_HALF) && top_half) ||
        ((bp == sfs_pkg::BP_QUARTER) && top_quarter);
    wire wr_ok = write_enable_latch && !prot;
    wire sr_ok = write_enable_latch && !(stat_nv[5] && !pins.wp_n);

    // The address steps after every array byte, a refused write too, so 13 bits wrap to zero.
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            addr <= '0;
        end else if (hi_done) begin
            addr[sfs_pkg::ADDR_W-1:8] <= next_byte[sfs_pkg::ADDR_W-9:0];
        end else if (lo_done) begin
            addr[7:0] <= next_byte;
        end else if (step) begin
            addr <= addr + 13'h1;
        end
    end

    // Read data arrives the cycle after the read strobe.
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            mem_we <= 1'b0;
            mem_re <= 1'b0;
            re_d <= 1'b0;
            step <= 1'b0;
            wdata <= 8'h00;
        end else begin
            mem_we <= data_done && op_mwrite && wr_ok;
            mem_re <= (lo_done || data_done) && op_mread;
            step <= (data_done && op_mwrite) || ((lo_done || data_done) && op_mread);
            re_d <= mem_re;
            if (data_done) begin
                wdata <= next_byte;
            end
        end
    end

    assign O_MEM = '{we: mem_we, re: mem_re, addr: addr, wdata: wdata};

    ////////////////////////////////////////////////////////////////////////////
    // Status register.

    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            stat_nv <= sfs_pkg::SR_NV_RESET;
            write_enable_latch <= sfs_pkg::SR_LATCH_RESET;
            wr_seen <= 1'b0;
        end else begin
            if (data_done && op_swrite && sr_ok) begin
                stat_nv <= next_byte[7:2];
            end
            if (is_enable) begin
                write_enable_latch <= 1'b1;
            end else if (is_disable || (cs_rise && wr_seen)) begin
                write_enable_latch <= 1'b0;
            end
            if (pins.cs_n) begin
                wr_seen <= 1'b0;
            end else if (cmd_done && (op_swrite || op_mwrite)) begin
                wr_seen <= 1'b1;
            end
        end
    end

    assign O_STATUS = {stat_nv, write_enable_latch, 1'b0};

    ////////////////////////////////////////////////////////////////////////////
    // Transmit path.

    wire [1:0] id_next = cmd_done ? 2'h0 : id_cnt + 2'h1;
    wire [31:0] id_shift = IDENT << {id_next, 3'b000};
    wire id_last = id_cnt == sfs_pkg::ID_LAST;
    wire load_now = re_d || (cmd_done && (op_sread || op_ident)) ||
        (data_done && (op_sread || (op_ident && !id_last)));
    wire [7:0] load_val = re_d ? I_MEM_RDATA : (op_sread ? O_STATUS : id_shift[31:24]);
    wire tx_en = (phase == sfs_pkg::PH_DATA) && (op_sread || op_ident || op_mread) && !freeze;

    // Loads happen a few cycles after a rising edge, well before the falling
    // edge that shifts; a link clock near our own rate would break this.
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            out_sh <= 8'h00;
            O_SO <= 1'b0;
            drv <= 1'b0;
            freeze <= 1'b0;
            id_cnt <= 2'h0;
        end else if (pins.cs_n) begin
            drv <= 1'b0;
            freeze <= 1'b0;
        end else begin
            if (load_now) begin
                out_sh <= load_val;
            end else if (sck_fall && tx_en) begin
                out_sh <= {out_sh[6:0], 1'b0};
            end
            if (sck_fall && tx_en) begin
                O_SO <= out_sh[7];
                drv <= 1'b1;
            end
            if (cmd_done) begin
                id_cnt <= 2'h0;
            end else if (data_done && op_ident) begin
                if (id_last) begin
                    freeze <= 1'b1;
                end else begin
                    id_cnt <= id_cnt + 2'h1;
                end
            end
        end
    end

    // Output enable drops while deselected or paused. Previous pin levels are
    // tracked even during a pause, so a pause left at the clock level it began
    // with produces no stray edge.
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_SO_OE <= 1'b0;
            sck_d <= sfs_pkg::PINS_RESET.sck;
            cs_d <= sfs_pkg::PINS_RESET.cs_n;
        end else begin
            O_SO_OE <= drv && active;
            sck_d <= pins.sck;
            cs_d <= pins.cs_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_RST_N);

    chk_deselect_idle: assert property (pins.cs_n |=> !O_SO_OE && bit_cnt == 3'h0)
        else $error("Output driven or bits counted while deselected.");
    chk_pause_freeze: assert property ((!pins.hold_n && !pins.cs_n) |=> !O_SO_OE && $stable(bit_cnt))
        else $error("Transfer moved during a pause.");
    chk_so_edge: assert property ($changed(O_SO) |-> $past(sck_fall))
        else $error("Serial output changed away from a falling edge.");
    chk_latch_set: assert property (is_enable |=> write_enable_latch ##1
        (write_enable_latch || $past(is_disable || cs_rise)))
        else $error("Enable command did not set the latch.");
    chk_latch_disable: assert property (is_disable |=> !write_enable_latch)
        else $error("Disable command did not clear the latch.");
    chk_latch_deselect: assert property ((cs_rise && wr_seen) |=> !write_enable_latch)
        else $error("Latch survived the end of a write command.");
    chk_bit_zero: assert property (O_STATUS[0] == 1'b0 && O_STATUS[1] == write_enable_latch)
        else $error("Status bit 0 is not zero.");
    chk_status_guard: assert property ($changed(stat_nv) |-> $past(data_done && op_swrite && sr_ok))
        else $error("Status changed without a permitted write.");
    chk_array_guard: assert property (mem_we |-> $past(wr_ok) && $past(data_done))
        else $error("Array written while latch clear or region protected.");
    chk_addr_step: assert property ((mem_we || mem_re) |=> addr == $past(addr) + 13'h1)
        else $error("Address did not step after an access.");

    cov_status_read: cover property (data_done && op_sread);
    cov_status_write: cover property (data_done && op_swrite && sr_ok);
    cov_mem_write: cover property (mem_we ##[1:400] mem_we);
    cov_ident_done: cover property (freeze && !pins.cs_n);
endmodule
`default_nettype wire

// [verilog/sfs_sync.sv]
// Two-stage synchroniser for a bundle of asynchronous pins.
`default_nettype none
module sfs_sync #(
    parameter int W = 5,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta;

    // The first stage feeds only the second stage.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta <= RST_VAL;
            o_q <= RST_VAL;
        end else begin
            meta <= i_d;
            o_q <= meta;
        end
    end
endmodule
`default_nettype wire
